/* logic/srcs_pkg.sv */
// Purpose: constants and types of the system reset and clock sequencer
// Assumes: one reference clock, counts in reference cycles
// Notes:   register map on a 32-bit APB slave
package srcs_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_CAUSE   = 12'h000;
    localparam logic [11:0] OFS_CONFIG  = 12'h004;
    localparam logic [11:0] OFS_STATUS  = 12'h008;
    // reset cause bit positions
    localparam int CAUSE_POR  = 0;
    localparam int CAUSE_PIN  = 1;
    localparam int CAUSE_WDOG = 2;
    localparam int CAUSE_ILLEGAL_OPCODE_FLAG = 3;
    localparam int CAUSE_ILLEGAL_ADDRESS_FLAG = 4;
    localparam int CAUSE_LVI  = 5;
    localparam logic [5:0] CAUSE_RESET = 6'h01;
    // configuration bit positions and reset value
    localparam int CFG_SHORT_REC = 0;
    localparam int CFG_STOP_EN   = 1;
    localparam int CFG_PLL_SEL   = 2;
    localparam logic [2:0] CFG_RESET = 3'h2;
    // cycle counts of the reference clock
    localparam logic [12:0] POR_LAST       = 13'h0FFF;  // 4096 cycles
    localparam logic [12:0] DRV_LAST       = 13'h001F;  // 32 cycles
    localparam logic [12:0] STOP_LONG_LAST = 13'h0FFF;  // 4096 cycles
    localparam logic [12:0] STOP_SHORT_LAST = 13'h001F; // 32 cycles
    localparam logic [12:0] PIN_SHORT      = 13'h0043;  // 67 cycles
    localparam logic [12:0] CNT_MAX        = 13'h1FFF;
    localparam logic [12:0] SVC_KEEP_MASK  = 13'h000F;  // bits 3..0 survive service
    localparam logic [1:0]  BUS_DIV_LAST   = 2'h3;      // divide by four
    // reset vectors
    localparam logic [15:0] VEC_MAIN = 16'hFFFE;
    localparam logic [15:0] VEC_MON  = 16'hFEFE;

    typedef enum logic [7:0] {
        ST_RUN     = 8'h01,
        ST_WAIT    = 8'h02,
        ST_STOP    = 8'h04,
        ST_STOPREC = 8'h08,
        ST_PORHOLD = 8'h10,
        ST_PINDRV  = 8'h20,
        ST_IRSTHLD = 8'h40,
        ST_EXTRST  = 8'h80
    } srcs_state_t;

    // decode signals from the cpu core
    typedef struct packed {
        logic illegalOpcode;
        logic stopExec;
        logic waitExec;
        logic opcodeFetch;
        logic unmappedAccess;
        logic watchdogService;   // write to the top memory location
    } srcs_cpu_dec_t;

    // test and mode conditions
    typedef struct packed {
        logic monitorMode;
        logic breakState;
        logic rstTestHigh;
        logic irqTestHigh;
    } srcs_mode_t;
endpackage : srcs_pkg

/* logic/srcs_top.sv */
// Purpose: reset sequencing, bus clock gating, cause flags and 13-bit system counter
// Assumes: clock is the reference oscillator clock; all inputs synchronous except
//          the reset pin and the watchdog overflow, which are synchronised here
// Notes:   registers on APB, zero wait state answer one cycle after setup
`timescale 1ns/1ps
`default_nettype none
module srcs_top #(
    parameter logic [12:0] PIN_LONG = 13'h1043   // 4163 cycles
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // detectors and clock sources
    input  wire logic                   lowVoltage,
    input  wire logic                   watchdogOverflow,
    input  wire logic                   pllTick,
    input  wire logic                   wakeEvent,
    // cpu decode and mode
    input  wire srcs_pkg::srcs_cpu_dec_t cpuDec,
    input  wire srcs_pkg::srcs_mode_t   mode,
    // external reset pin, open drain
    input  wire logic                   rstPinIn,
    output logic                        rstPinOut,
    output logic                        rstPinOe,
    // clocks and resets toward core and peripherals
    output logic                        internalReset,
    output logic                        cpuClockEn,
    output logic                        periphClockEn,
    output logic                        busTick,
    output logic                        clockGenEnable,
    output logic [15:0]                 resetVector,
    // watchdog side
    output logic                        watchdogTick,
    output logic                        watchdogClear,
    output logic                        watchdogDisable,
    output logic [12:0]                 sysCount
);

    typedef struct packed {
        srcs_pkg::srcs_state_t state;
        logic [12:0] sysCount;
        logic [12:0] phaseCount;
        logic [12:0] pinLowCount;
        logic        porLviSeq;
        logic [5:0]  cause;
        logic [2:0]  cfgBits;
        logic [1:0]  busDiv;
        logic        pinSync1;
        logic        pinSync2;
        logic        wdSync1;
        logic        wdSync2;
        logic        wdPrev;
        logic        rstPinOe;
        logic        internalReset;
        logic        cpuClockEn;
        logic        periphClockEn;
        logic        busTick;
        logic        clockGenEnable;
        logic [15:0] resetVector;
        logic        wdTick;
        logic        wdClear;
        logic        wdDisable;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } srcs_regs_t;

    srcs_regs_t r_r;
    srcs_regs_t r_nxt;

    logic        pinLow;
    logic        wdEvent;
    logic        inSeq;
    logic        ilopReq;
    logic        iladReq;
    logic        busAdvance;
    logic        setupPhase;
    logic        mapped;
    logic [12:0] countInc;
    logic [12:0] pinThreshold;
    logic [12:0] stopLast;

    always_comb begin
        r_nxt = r_r;
        // the first stages feed only the second stages
        r_nxt.pinSync1 = rstPinIn;
        r_nxt.pinSync2 = r_r.pinSync1;
        r_nxt.wdSync1  = watchdogOverflow;
        r_nxt.wdSync2  = r_r.wdSync1;
        r_nxt.wdPrev   = r_r.wdSync2;
        pinLow  = ~r_r.pinSync2;
        wdEvent = r_r.wdSync2 & ~r_r.wdPrev & ~r_r.wdDisable;
        inSeq   = (r_r.state == srcs_pkg::ST_PORHOLD) || (r_r.state == srcs_pkg::ST_PINDRV)
               || (r_r.state == srcs_pkg::ST_IRSTHLD);
        ilopReq = cpuDec.illegalOpcode
               || (cpuDec.stopExec && !r_r.cfgBits[srcs_pkg::CFG_STOP_EN]);
        iladReq = cpuDec.unmappedAccess && cpuDec.opcodeFetch;

        // free-running counter, overflow feeds the watchdog prescale
        countInc = r_r.sysCount + 13'h0001;
        r_nxt.sysCount = countInc;
        r_nxt.wdTick   = (r_r.sysCount == srcs_pkg::CNT_MAX);
        r_nxt.wdClear  = cpuDec.watchdogService;
        if (cpuDec.watchdogService) begin
            r_nxt.sysCount = countInc & srcs_pkg::SVC_KEEP_MASK;
        end

        // bus clock divider on the selected source
        busAdvance = !r_r.cfgBits[srcs_pkg::CFG_PLL_SEL] || pllTick;
        if (busAdvance) begin
            r_nxt.busDiv = r_r.busDiv + 2'h1;
        end
        r_nxt.busTick = busAdvance && (r_r.busDiv == srcs_pkg::BUS_DIV_LAST);

        // pin low time; long threshold while a power-on or low-voltage sequence is open
        pinThreshold = r_r.porLviSeq ? PIN_LONG : srcs_pkg::PIN_SHORT;
        if (pinLow) begin
            if (r_r.pinLowCount != srcs_pkg::CNT_MAX) begin
                r_nxt.pinLowCount = r_r.pinLowCount + 13'h0001;
            end
            if (r_r.pinLowCount == pinThreshold - 13'h0001) begin
                r_nxt.cause = (r_r.porLviSeq ? r_r.cause : 6'h00)
                            | (6'h01 << srcs_pkg::CAUSE_PIN);
            end
        end else begin
            r_nxt.pinLowCount = 13'h0000;
        end

        stopLast = r_r.cfgBits[srcs_pkg::CFG_SHORT_REC] ? srcs_pkg::STOP_SHORT_LAST
                                                       : srcs_pkg::STOP_LONG_LAST;
        r_nxt.phaseCount = r_r.phaseCount + 13'h0001;

        case (r_r.state)
            srcs_pkg::ST_RUN: begin
                if (cpuDec.stopExec && r_r.cfgBits[srcs_pkg::CFG_STOP_EN]) begin
                    r_nxt.state    = srcs_pkg::ST_STOP;
                    r_nxt.sysCount = 13'h0000;
                end else if (cpuDec.waitExec) begin
                    r_nxt.state = srcs_pkg::ST_WAIT;
                end
                if (!r_r.pinLowCount[0] && !pinLow) begin
                    r_nxt.porLviSeq = 1'b0;
                end
            end
            srcs_pkg::ST_WAIT: begin
                if (wakeEvent) begin
                    r_nxt.state = srcs_pkg::ST_RUN;
                end
            end
            srcs_pkg::ST_STOP: begin
                // oscillator stands still: counter held at zero
                r_nxt.sysCount = 13'h0000;
                if (wakeEvent || pinLow) begin
                    r_nxt.state = srcs_pkg::ST_STOPREC;
                end
            end
            srcs_pkg::ST_STOPREC: begin
                if (r_r.sysCount == stopLast) begin
                    r_nxt.state = srcs_pkg::ST_RUN;
                end
            end
            srcs_pkg::ST_PORHOLD: begin
                if (r_r.sysCount == srcs_pkg::POR_LAST) begin
                    r_nxt.state      = srcs_pkg::ST_PINDRV;
                    r_nxt.phaseCount = 13'h0000;
                end
            end
            srcs_pkg::ST_PINDRV: begin
                if (r_r.phaseCount == srcs_pkg::DRV_LAST) begin
                    r_nxt.state      = srcs_pkg::ST_IRSTHLD;
                    r_nxt.phaseCount = 13'h0000;
                end
            end
            srcs_pkg::ST_IRSTHLD: begin
                if (r_r.phaseCount == srcs_pkg::DRV_LAST) begin
                    r_nxt.state = srcs_pkg::ST_RUN;
                end
            end
            srcs_pkg::ST_EXTRST: begin
                if (!pinLow) begin
                    r_nxt.state = srcs_pkg::ST_RUN;
                end
            end
            default: begin
                r_nxt.state = srcs_pkg::ST_PORHOLD;
            end
        endcase

        // pin pulled low from outside: counter untouched
        if (pinLow && !r_r.rstPinOe && ((r_r.state == srcs_pkg::ST_RUN)
                || (r_r.state == srcs_pkg::ST_WAIT))) begin
            r_nxt.state = srcs_pkg::ST_EXTRST;
        end

        // internal sources, low voltage first
        if (!inSeq) begin
            if (lowVoltage) begin
                r_nxt.state     = srcs_pkg::ST_PORHOLD;
                r_nxt.cause     = 6'h01 << srcs_pkg::CAUSE_LVI;
                r_nxt.sysCount  = 13'h0000;
                r_nxt.porLviSeq = 1'b1;
            end else if (wdEvent || (r_r.state == srcs_pkg::ST_RUN && (ilopReq || iladReq))) begin
                r_nxt.state      = srcs_pkg::ST_PINDRV;
                r_nxt.phaseCount = 13'h0000;
                r_nxt.sysCount   = 13'h0000;
                if (wdEvent) begin
                    r_nxt.cause = 6'h01 << srcs_pkg::CAUSE_WDOG;
                end else if (ilopReq) begin
                    r_nxt.cause = 6'h01 << srcs_pkg::CAUSE_ILLEGAL_OPCODE_FLAG;
                end else begin
                    r_nxt.cause = 6'h01 << srcs_pkg::CAUSE_ILLEGAL_ADDRESS_FLAG;
                end
            end
        end

        // outputs follow the next state so that they leave flip-flops aligned with it
        r_nxt.rstPinOe      = (r_nxt.state == srcs_pkg::ST_PORHOLD)
                           || (r_nxt.state == srcs_pkg::ST_PINDRV);
        r_nxt.internalReset = r_nxt.rstPinOe || (r_nxt.state == srcs_pkg::ST_IRSTHLD)
                           || (r_nxt.state == srcs_pkg::ST_EXTRST);
        r_nxt.cpuClockEn    = (r_nxt.state == srcs_pkg::ST_RUN);
        r_nxt.periphClockEn = (r_nxt.state == srcs_pkg::ST_RUN)
                           || (r_nxt.state == srcs_pkg::ST_WAIT);
        r_nxt.clockGenEnable = 1'b1;
        r_nxt.resetVector   = mode.monitorMode ? srcs_pkg::VEC_MON : srcs_pkg::VEC_MAIN;
        // plain gating of the test-voltage detects, nothing else can disable
        r_nxt.wdDisable     = (mode.monitorMode && (mode.rstTestHigh || mode.irqTestHigh))
                           || (mode.breakState && mode.rstTestHigh);

        // apb: answer in the access phase, reads have no side effect
        setupPhase = psel && !penable;
        mapped = (paddr == srcs_pkg::OFS_CAUSE) || (paddr == srcs_pkg::OFS_CONFIG)
              || (paddr == srcs_pkg::OFS_STATUS);
        r_nxt.pready  = setupPhase;
        r_nxt.pslverr = setupPhase && !mapped;
        r_nxt.prdata  = 32'h0000_0000;
        if (setupPhase && !pwrite) begin
            case (paddr)
                srcs_pkg::OFS_CAUSE:  r_nxt.prdata = {26'h0, r_r.cause};
                srcs_pkg::OFS_CONFIG: r_nxt.prdata = {29'h0, r_r.cfgBits};
                srcs_pkg::OFS_STATUS: r_nxt.prdata = {11'h0, r_r.state, r_r.sysCount};
                default:              r_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && r_r.pready && pwrite && (paddr == srcs_pkg::OFS_CONFIG)) begin
            r_nxt.cfgBits = pwdata[2:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // rst_n stands for power-on: sequence opens in the long hold
            r_r                <= '0;
            r_r.state          <= srcs_pkg::ST_PORHOLD;
            r_r.cause          <= srcs_pkg::CAUSE_RESET;
            r_r.cfgBits        <= srcs_pkg::CFG_RESET;
            r_r.porLviSeq      <= 1'b1;
            r_r.pinSync1       <= 1'b1;
            r_r.pinSync2       <= 1'b1;
            r_r.rstPinOe       <= 1'b1;
            r_r.internalReset  <= 1'b1;
            r_r.resetVector    <= srcs_pkg::VEC_MAIN;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign prdata          = r_r.prdata;
    assign pready          = r_r.pready;
    assign pslverr         = r_r.pslverr;
    assign rstPinOut       = 1'b0;
    assign rstPinOe        = r_r.rstPinOe;
    assign internalReset   = r_r.internalReset;
    assign cpuClockEn      = r_r.cpuClockEn;
    assign periphClockEn   = r_r.periphClockEn;
    assign busTick         = r_r.busTick;
    assign clockGenEnable  = r_r.clockGenEnable;
    assign resetVector     = r_r.resetVector;
    assign watchdogTick    = r_r.wdTick;
    assign watchdogClear   = r_r.wdClear;
    assign watchdogDisable = r_r.wdDisable;
    assign sysCount        = r_r.sysCount;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_quiet_three;
        !busTick [*3];
    endsequence
    property p_bus_quarter;
        (busTick && !r_r.cfgBits[srcs_pkg::CFG_PLL_SEL] && !psel)
            |-> ##1 s_quiet_three ##1 (busTick || r_r.cfgBits[srcs_pkg::CFG_PLL_SEL]);
    endproperty
    a_bus_quarter: assert property (p_bus_quarter) else $error("bus tick not every fourth cycle");

    property p_hold_clocks_off;
        (r_r.state == srcs_pkg::ST_PORHOLD) |-> (rstPinOe && !cpuClockEn && !periphClockEn);
    endproperty
    a_hold_clocks_off: assert property (p_hold_clocks_off) else $error("clock or pin wrong in hold");

    sequence s_drive_end;
        (r_r.state == srcs_pkg::ST_PINDRV) && (r_r.phaseCount == srcs_pkg::DRV_LAST)
            && !lowVoltage;
    endsequence
    property p_drive_then_hold;
        s_drive_end |=> (!rstPinOe && internalReset && r_r.phaseCount == 13'h0000);
    endproperty
    a_drive_then_hold: assert property (p_drive_then_hold) else $error("pin drive phase wrong");

    property p_ext_keeps_count;
        (r_r.state == srcs_pkg::ST_EXTRST && !cpuDec.watchdogService && !lowVoltage && !wdEvent)
            |=> (sysCount == $past(sysCount) + 13'h0001);
    endproperty
    a_ext_keeps_count: assert property (p_ext_keeps_count) else $error("pin reset altered counter");

    property p_service;
        (cpuDec.watchdogService && !lowVoltage && !wdEvent)
            |=> (sysCount[12:4] == 9'h000 && watchdogClear);
    endproperty
    a_service: assert property (p_service) else $error("service did not clear counter");

    property p_illegal_opcode_flag;
        (r_r.state == srcs_pkg::ST_RUN && cpuDec.illegalOpcode && !lowVoltage && !wdEvent)
            |=> (r_r.state == srcs_pkg::ST_PINDRV && r_r.cause[srcs_pkg::CAUSE_ILLEGAL_OPCODE_FLAG]
                 && sysCount == 13'h0000) ##32 (r_r.state == srcs_pkg::ST_IRSTHLD);
    endproperty
    a_illegal_opcode_flag: assert property (p_illegal_opcode_flag) else $error("illegal opcode reset wrong");

    property p_data_fetch;
        (r_r.state == srcs_pkg::ST_RUN && cpuDec.unmappedAccess && !cpuDec.opcodeFetch
            && !ilopReq && !lowVoltage && !wdEvent && !cpuDec.stopExec && !cpuDec.waitExec
            && !pinLow) |=> (r_r.state == srcs_pkg::ST_RUN);
    endproperty
    a_data_fetch: assert property (p_data_fetch) else $error("data fetch caused reset");

    property p_short_stop;
        (r_r.state == srcs_pkg::ST_STOPREC && r_r.cfgBits[srcs_pkg::CFG_SHORT_REC]
            && sysCount == srcs_pkg::STOP_SHORT_LAST && !lowVoltage && !wdEvent)
            |=> (cpuClockEn && periphClockEn);
    endproperty
    a_short_stop: assert property (p_short_stop) else $error("short stop recovery wrong");

    property p_wait_clocks;
        (r_r.state == srcs_pkg::ST_WAIT) |-> (!cpuClockEn && periphClockEn);
    endproperty
    a_wait_clocks: assert property (p_wait_clocks) else $error("wait mode clocks wrong");

endmodule : srcs_top
`default_nettype wire

/* tb/srcs_far_side.sv */
// Purpose: reset pin wire with its pull-up and an outside party
// Assumes: open drain, a released pin floats high
// Notes:   the device and the outside party may both pull low
`timescale 1ns/1ps
`default_nettype none
module srcs_far_side (
    // pin drivers
    input  wire logic rstPinOut,
    input  wire logic rstPinOe,
    input  wire logic extPull,
    // wire level
    output logic      pinLevel
);
    // pull-up wins whenever nobody drives low
    assign pinLevel = !((rstPinOe && !rstPinOut) || extPull);
endmodule : srcs_far_side
`default_nettype wire

/* tb/srcs_top_bench.sv */
// Purpose: self-checking bench of the reset and clock sequencer
// Assumes: reads queue their expected word, the monitor compares
// Notes:   timeout ends the run through the closing task
`timescale 1ns/1ps
`default_nettype none
module srcs_top_bench;
    logic        clock = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, pinLvl, pinOut, pinOe, internal_reset, cpuEn, perEn, busTick, cge;
    logic        lowV = 0, wdog = 0, wake = 0, extPull = 0, pll = 0, wdTick, wdClr, wdDis;
    logic [15:0] vec;
    logic [12:0] sysCount, snap;
    logic [32:0] expQ[$];
    int          mismatches = 0, check_count = 0, cycles = 0, seed = 32'hA10C, n, m;
    int          bitTab[5] = '{2, 3, 4, 3, 5};
    srcs_pkg::srcs_cpu_dec_t cpuDec = '0;
    srcs_pkg::srcs_mode_t    mode = '0;

    srcs_top i_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lowVoltage(lowV), .watchdogOverflow(wdog), .pllTick(pll),
        .wakeEvent(wake), .cpuDec(cpuDec), .mode(mode), .rstPinIn(pinLvl),
        .rstPinOut(pinOut), .rstPinOe(pinOe), .internalReset(internal_reset), .cpuClockEn(cpuEn),
        .periphClockEn(perEn), .busTick(busTick), .clockGenEnable(cge), .resetVector(vec),
        .watchdogTick(wdTick), .watchdogClear(wdClr), .watchdogDisable(wdDis),
        .sysCount(sysCount));
    srcs_far_side i_far (.rstPinOut(pinOut), .rstPinOe(pinOe), .extPull(extPull),
        .pinLevel(pinLvl));

    always #10 clock = ~clock;
    // pll source ticks every other reference cycle
    always @(posedge clock) pll <= ~pll;

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // the run should take about 17000 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, expQ.pop_front());
        if (cycles > 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, e,
                       input logic er);
        @(posedge clock);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) expQ.push_back({er, e});
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic settle(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : settle

    task automatic seq(input int pinLen, input logic [5:0] cause);
        m = 0;
        while (pinOe === 1'b1) begin settle(1); m++; end
        if (pinLen > 0) chk(m, pinLen);
        m = 0;
        while (internal_reset === 1'b1) begin settle(1); m++; end
        chk(m, 32);
        apb(0, srcs_pkg::OFS_CAUSE, 0, cause, 0);
    endtask : seq

    task automatic fire(input int k);
        @(posedge clock);
        case (k)
            0: wdog <= 1;
            1: cpuDec.illegalOpcode <= 1;
            2: cpuDec <= 6'h06;
            3: cpuDec.stopExec <= 1;
            default: lowV <= 1;
        endcase
        @(posedge clock);
        cpuDec <= '0;
        lowV <= 0;
        wdog <= 0;
        #1;
        n = 0;
        while (pinOe !== 1'b1 && n < 9) begin settle(1); n++; end
        seq(k == 4 ? 4128 : 32, 6'h01 << bitTab[k]);
    endtask : fire

    task automatic pin(input int len, input logic [5:0] cause);
        @(posedge clock);
        extPull <= 1;
        settle(5);
        snap = sysCount;
        settle(1);
        chk(sysCount, snap + 13'h0001);
        repeat (len) @(posedge clock);
        extPull <= 0;
        settle(5);
        n = 0;
        while (internal_reset === 1'b1 && n < 200) begin settle(1); n++; end
        apb(0, srcs_pkg::OFS_CAUSE, 0, cause, 0);
    endtask : pin

    task automatic pulse(input logic [5:0] d, input logic w);
        @(posedge clock);
        cpuDec <= d;
        wake <= w;
        @(posedge clock);
        cpuDec <= '0;
        wake <= 0;
        #1;
    endtask : pulse

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        settle(1);
        chk(cge, 1);
        seq(0, 6'h01);
        apb(0, srcs_pkg::OFS_CONFIG, 0, 32'h2, 0);
        apb(1, srcs_pkg::OFS_CAUSE, $random(seed), 0, 0);
        apb(0, srcs_pkg::OFS_CAUSE, 0, 32'h1, 0);
        apb(0, 12'h0FC, 0, 0, 1);
        while (busTick !== 1'b1) settle(1);
        n = 0;
        do begin settle(1); n++; end while (busTick !== 1'b1);
        chk(n, 4);
        @(posedge clock);
        mode <= 4'hA;
        settle(3);
        chk(vec, srcs_pkg::VEC_MON);
        chk(wdDis, 1);
        @(posedge clock);
        mode <= 4'h1;
        settle(3);
        chk(vec, srcs_pkg::VEC_MAIN);
        chk(wdDis, 0);
        @(posedge clock);
        mode <= 4'h6;
        settle(3);
        chk(wdDis, 1);
        @(posedge clock);
        mode <= '0;
        pulse(6'h01, 0);
        chk(wdClr, 1);
        chk(sysCount[12:4], 0);
        while (wdTick !== 1'b1) settle(1);
        chk(sysCount, 0);
        pulse(6'h08, 0);
        settle(2);
        chk({cpuEn, perEn}, 2'b01);
        pulse(6'h00, 1);
        apb(1, srcs_pkg::OFS_CONFIG, 32'h3, 0, 0);
        pulse(6'h10, 0);
        settle(4);
        chk({cpuEn, sysCount}, 0);
        pulse(6'h00, 1);
        n = 0;
        while (cpuEn !== 1'b1 && n < 5000) begin settle(1); n++; end
        chk(n >= 31 && n <= 33, 1);
        pulse(6'h02, 0);
        settle(4);
        chk(internal_reset, 0);
        for (int k = 0; k < 5; k++) begin
            if (k == 3) apb(1, srcs_pkg::OFS_CONFIG, 0, 0, 0);
            fire(k);
        end
        apb(1, srcs_pkg::OFS_CONFIG, 32'h4, 0, 0);
        settle(16);
        while (busTick !== 1'b1) settle(1);
        n = 0;
        do begin settle(1); n++; end while (busTick !== 1'b1);
        chk(n, 8);
        settle(8);
        chk(sysCount === 0, 0);
        pin(20 + ($random(seed) & 31), 6'h20);
        pin(80, 6'h02);
        tally_and_finish();
    end
endmodule : srcs_top_bench
`default_nettype wire
